// [rtl/pmw_ctrl.sv]
// power mode, clock select and wake-up controller with axi4-lite registers
// Overview of operation
// - slow crystal runs quick-start when low-power select is 0, low power when 1.
// - power-on clears the low-power select bit, quick-start first.
// - slow crystal clock stays valid in both low-power settings.
// - slow rc oscillator keeps running in idle and sleep unless disabled.
// - four modes normal, slow, idle, sleep with their oscillator states.
// - slow-select bit picks fast rc or slow crystal as system clock.
// - slow-select only acts in the fast rc plus slow crystal configuration.
// - slow crystal usable only with fast rc, never with crystal or ext rc.
// - halt enters idle if slow crystal runs, else sleep, ignoring slow-select.
// - slow crystal keeps running during idle in the combined configuration.
// - sleep stops the system oscillator and execution, keeping state.
// - halt clears watchdog; it runs on own clocks, stops on system clock.
// - halt sets power-down flag and clears the time-out flag.
// - wake on external reset, port a falling edge, interrupt or watchdog.
// - reset wake is full reset; watchdog wake sets time-out, resets pc/sp.
// - power-down flag cleared by power-up or clear-watchdog, set by halt.
// - enabled port a lines wake on falling edge, resume after halt.
// - disabled or stack-full interrupt wake resumes after halt, stays pending.
// - interrupt already pending before halt does not wake the device.
// - wake delay 2 system clocks with rc, 128 with crystal oscillators.
// - reset wake waits power-on wait plus 128-clock start-up delay.
// - low-power select is bit 1 of system control zero.
// - slow-select is bit 0 of system control zero; 1 stops fast rc.
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module pmw_ctrl
    import pmw_pkg::*;
#(
    parameter int RESET_WAIT_CYC = POWER_ON_WAIT_CYC
) (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic fast_clk_in,
    input wire logic slow_clk_in,
    input wire logic external_clear_pin_b_in,
    input wire logic [7:0] port_a_in,
    input wire logic [7:0] irq_req_in,
    input wire logic [7:0] irq_enabled_in,
    input wire logic stack_full_in,
    input wire logic wdt_overflow_in,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output pmw_osc_s osc_out,
    output logic sys_clk_out,
    output logic cpu_run_out,
    output logic wdt_clear_out,
    output logic wdt_run_out,
    output logic pc_sp_reset_out,
    output logic full_reset_out,
    output logic irq_service_out
);
    // synchronised pins and oscillator samples
    logic [7:0] pa_s;
    logic [7:0] irq_s;
    logic [3:0] misc_s;
    pmw_sync #(.W(8)) u_sync_pa (
        .clock_in(clock_in), .rst_b_in(rst_b_in), .d_in(port_a_in), .q_out(pa_s));
    pmw_sync #(.W(8)) u_sync_irq (
        .clock_in(clock_in), .rst_b_in(rst_b_in), .d_in(irq_req_in), .q_out(irq_s));
    pmw_sync #(.W(4)) u_sync_misc (
        .clock_in(clock_in), .rst_b_in(rst_b_in),
        .d_in({external_clear_pin_b_in, wdt_overflow_in, fast_clk_in, slow_clk_in}),
        .q_out(misc_s));
    wire logic clr_pin_b = misc_s[3];
    wire logic wdt_ovf = misc_s[2];
    wire logic fast_clk_s = misc_s[1];
    wire logic slow_clk_s = misc_s[0];

    // registers
    logic [7:0] system_control_zero;
    logic [7:0] port_a_wake_mask;
    logic [3:0] osc_config;
    logic power_down_flag;
    logic watchdog_expiry_flag;
    logic [7:0] pa_prev;
    logic [7:0] irq_prev;
    logic [7:0] irq_masked;
    pmw_state_e state;
    logic [31:0] dly;
    logic dly_long;
    logic clk_use_slow;
    logic fast_clk_q;
    logic slow_clk_q;
    logic [7:0] next_system_control_zero;
    logic [7:0] next_port_a_wake_mask;
    logic [3:0] next_osc_config;
    logic next_power_down_flag;
    logic next_watchdog_expiry_flag;
    logic [7:0] next_irq_masked;
    pmw_state_e next_state;
    logic [31:0] next_dly;
    logic next_dly_long;
    logic next_clk_use_slow;
    logic [4:0] next_ctl;

    // config: [1:0] oscillator choice, [2] watchdog on system clock, [3] slow rc off
    wire logic combo_cfg = (osc_config[1:0] == OSC_RC_PLUS_XTAL);
    wire logic is_crystal = (osc_config[1:0] == OSC_FAST_XTAL);
    wire logic xtal_running = combo_cfg;
    wire logic want_slow = combo_cfg && system_control_zero[BIT_CLK_SLOW_SEL];

    // axi4-lite slave, one outstanding write and read
    logic aw_hold;
    logic w_hold;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire logic wr_fire = aw_hold && w_hold && !s_axi_bvalid;
    logic [31:0] rd_val;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        rd_val = 32'h0000_0000;
        case (s_axi_araddr)
            ADDR_SYSTEM_CONTROL_ZERO: rd_val = {24'h000000, system_control_zero};
            ADDR_STATUS: rd_val = {24'h000000, 1'b0, state, watchdog_expiry_flag,
                power_down_flag};
            ADDR_WAKE_MASK: rd_val = {24'h000000, port_a_wake_mask};
            ADDR_COMMAND: rd_val = 32'h0000_0000;
            ADDR_CONFIG: rd_val = {28'h0000000, osc_config};
            default: rd_ok = 1'b0;
        endcase
    end
    wire logic wr_ok = (aw_addr == ADDR_SYSTEM_CONTROL_ZERO) || (aw_addr == ADDR_STATUS) ||
        (aw_addr == ADDR_WAKE_MASK) || (aw_addr == ADDR_COMMAND) || (aw_addr == ADDR_CONFIG);
    wire logic wr_b0 = wr_fire && w_strb[0];
    wire logic halt_cmd = wr_b0 && (aw_addr == ADDR_COMMAND) && w_data[BIT_CMD_HALT]
        && (state == PMW_RUN);
    wire logic clrwdt_cmd = wr_b0 && (aw_addr == ADDR_COMMAND) && w_data[BIT_CMD_CLRWDT];

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 32'h0000_0000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // wake sources
    wire logic [7:0] pa_fall = pa_prev & ~pa_s & port_a_wake_mask;
    wire logic [7:0] irq_rise = irq_s & ~irq_prev & ~irq_masked;
    wire logic halted = (state == PMW_IDLE) || (state == PMW_SLEEP);
    wire logic wake_evt = halted && ((|pa_fall) || (|irq_rise) || wdt_ovf);

    // mode, flags and control registers
    always_comb begin
        next_system_control_zero = system_control_zero;
        next_port_a_wake_mask = port_a_wake_mask;
        next_osc_config = osc_config;
        next_power_down_flag = power_down_flag;
        next_watchdog_expiry_flag = watchdog_expiry_flag;
        next_irq_masked = irq_masked;
        next_state = state;
        next_dly = dly;
        next_dly_long = dly_long;
        next_ctl = 5'h00;
        if (wr_b0 && aw_addr == ADDR_SYSTEM_CONTROL_ZERO) begin
            next_system_control_zero = w_data[7:0];
        end
        if (wr_b0 && aw_addr == ADDR_WAKE_MASK) begin
            next_port_a_wake_mask = w_data[7:0];
        end
        if (wr_b0 && aw_addr == ADDR_CONFIG) begin
            next_osc_config = w_data[3:0];
        end
        if (clrwdt_cmd) begin
            next_power_down_flag = 1'b0;
            next_ctl[0] = 1'b1;
        end
        case (state)
            PMW_RUN: begin
                if (halt_cmd) begin
                    next_power_down_flag = 1'b1;
                    next_watchdog_expiry_flag = 1'b0;
                    next_irq_masked = irq_s;
                    next_ctl[0] = 1'b1;
                    next_state = xtal_running ? PMW_IDLE : PMW_SLEEP;
                end
            end
            PMW_IDLE, PMW_SLEEP: begin
                if (wake_evt) begin
                    next_dly = (is_crystal ? LONG_STARTUP_DELAY : SHORT_STARTUP_DELAY) - 1;
                    next_dly_long = 1'b0;
                    if (wdt_ovf) begin
                        next_watchdog_expiry_flag = 1'b1;
                        next_ctl[1] = 1'b1;
                    end
                    next_ctl[3] = (|irq_rise) && (|(irq_rise & irq_enabled_in))
                        && !stack_full_in;
                    next_state = PMW_WAKE;
                end
            end
            PMW_WAKE: begin
                if (dly == 32'h0000_0000) begin
                    next_state = PMW_RUN;
                end else begin
                    next_dly = dly - 32'h0000_0001;
                end
            end
            PMW_RSTWAIT: begin
                if (dly == 32'h0000_0000 && !dly_long) begin
                    next_state = PMW_RUN;
                end else if (dly == 32'h0000_0000) begin
                    next_dly = LONG_STARTUP_DELAY - 1;
                    next_dly_long = 1'b0;
                end else begin
                    next_dly = dly - 32'h0000_0001;
                end
            end
            default: next_state = PMW_RUN;
        endcase
        // external reset wins over everything, a full reset with the long wait
        if (!clr_pin_b) begin
            next_ctl[2] = 1'b1;
            next_power_down_flag = 1'b0;
            next_watchdog_expiry_flag = 1'b0;
            next_system_control_zero = SYS_CTRL_ZERO_RESET;
            next_port_a_wake_mask = WAKE_MASK_RESET;
            next_dly = RESET_WAIT_CYC - 1;
            next_dly_long = 1'b1;
            next_state = PMW_RSTWAIT;
        end
    end

    // glitch-free switch: move only while both clocks sit low
    always_comb begin
        next_clk_use_slow = clk_use_slow;
        if (want_slow != clk_use_slow && !fast_clk_q && !slow_clk_q) begin
            next_clk_use_slow = want_slow;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            system_control_zero <= SYS_CTRL_ZERO_RESET;
            port_a_wake_mask <= WAKE_MASK_RESET;
            osc_config <= CONFIG_RESET;
            power_down_flag <= 1'b0;
            watchdog_expiry_flag <= 1'b0;
            irq_masked <= 8'h00;
            pa_prev <= 8'hff;
            irq_prev <= 8'h00;
            state <= PMW_RUN;
            dly <= 32'h0000_0000;
            dly_long <= 1'b0;
            clk_use_slow <= 1'b0;
            fast_clk_q <= 1'b0;
            slow_clk_q <= 1'b0;
            osc_out <= '0;
            sys_clk_out <= 1'b0;
            cpu_run_out <= 1'b1;
            wdt_clear_out <= 1'b0;
            wdt_run_out <= 1'b1;
            pc_sp_reset_out <= 1'b0;
            full_reset_out <= 1'b0;
            irq_service_out <= 1'b0;
        end else begin
            system_control_zero <= next_system_control_zero;
            port_a_wake_mask <= next_port_a_wake_mask;
            osc_config <= next_osc_config;
            power_down_flag <= next_power_down_flag;
            watchdog_expiry_flag <= next_watchdog_expiry_flag;
            irq_masked <= next_irq_masked & irq_s;
            pa_prev <= pa_s;
            irq_prev <= irq_s;
            state <= next_state;
            dly <= next_dly;
            dly_long <= next_dly_long;
            clk_use_slow <= next_clk_use_slow;
            fast_clk_q <= fast_clk_s;
            slow_clk_q <= slow_clk_s;
            // fast rc stops in slow mode and when halted
            osc_out.fast_rc_run <= (next_state == PMW_RUN || next_state == PMW_WAKE
                || next_state == PMW_RSTWAIT) && !(combo_cfg && next_clk_use_slow);
            osc_out.slow_xtal_run <= combo_cfg;
            osc_out.slow_xtal_lp <= next_system_control_zero[BIT_XTAL_LOW_POWER];
            osc_out.slow_rc_run <= !next_osc_config[BIT_CFG_SLOW_RC_OFF];
            osc_out.sys_slow <= next_clk_use_slow;
            sys_clk_out <= next_clk_use_slow ? slow_clk_s : fast_clk_s;
            cpu_run_out <= (next_state == PMW_RUN);
            wdt_clear_out <= next_ctl[0] | next_ctl[2];
            wdt_run_out <= !((next_state == PMW_IDLE || next_state == PMW_SLEEP)
                && next_osc_config[BIT_CFG_WDT_SYS]);
            pc_sp_reset_out <= next_ctl[1];
            full_reset_out <= next_ctl[2];
            irq_service_out <= next_ctl[3];
        end
    end

    a_halt_flags: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        halt_cmd && clr_pin_b |=> power_down_flag && !watchdog_expiry_flag)
        else $error("halt did not set power-down and clear time-out");
    a_halt_mode: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        halt_cmd && clr_pin_b |=> (state == (xtal_running ? PMW_IDLE : PMW_SLEEP)))
        else $error("halt entered wrong low power mode");
    a_lp_follows: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        osc_out.slow_xtal_lp == system_control_zero[BIT_XTAL_LOW_POWER])
        else $error("low power select not applied");
    a_short_wake: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        wake_evt && clr_pin_b && !is_crystal ##1 (clr_pin_b && !is_crystal) [*2]
        |=> state == PMW_RUN)
        else $error("rc wake delay wrong");
    a_wdt_wake: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        wake_evt && wdt_ovf && clr_pin_b |=> watchdog_expiry_flag && pc_sp_reset_out)
        else $error("watchdog wake did not set time-out");
    a_slow_ignored: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !combo_cfg && !clk_use_slow |=> !clk_use_slow)
        else $error("slow select acted outside combined setting");
    a_reset_wait: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !clr_pin_b |=> state == PMW_RSTWAIT && full_reset_out)
        else $error("reset wake not started");
    a_sleep_stop: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        $past(state) == PMW_SLEEP && state == PMW_SLEEP |-> !cpu_run_out && !osc_out.fast_rc_run)
        else $error("sleep left execution running");
endmodule : pmw_ctrl

// [rtl/pmw_pkg.sv]
// shared constants and types for the power mode and wake-up controller
package pmw_pkg;
    localparam logic [31:0] ADDR_SYSTEM_CONTROL_ZERO = 32'h0000_0000;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
    localparam logic [31:0] ADDR_WAKE_MASK = 32'h0000_0008;
    localparam logic [31:0] ADDR_COMMAND = 32'h0000_000c;
    localparam logic [31:0] ADDR_CONFIG = 32'h0000_0010;
    localparam int BIT_CLK_SLOW_SEL = 0;
    localparam int BIT_XTAL_LOW_POWER = 1;
    localparam int BIT_STAT_POWER_DOWN = 0;
    localparam int BIT_STAT_EXPIRY = 1;
    localparam int BIT_CMD_HALT = 0;
    localparam int BIT_CMD_CLRWDT = 1;
    localparam int BIT_CFG_WDT_SYS = 2;
    localparam int BIT_CFG_SLOW_RC_OFF = 3;
    localparam logic [1:0] OSC_FAST_XTAL = 2'h0;
    localparam logic [1:0] OSC_EXT_RC = 2'h1;
    localparam logic [1:0] OSC_FAST_RC = 2'h2;
    localparam logic [1:0] OSC_RC_PLUS_XTAL = 2'h3;
    localparam logic [1:0] WDT_SRC_SLOW_RC = 2'h0;
    localparam logic [1:0] WDT_SRC_XTAL = 2'h1;
    localparam logic [1:0] WDT_SRC_SYS = 2'h2;
    localparam logic [7:0] SYS_CTRL_ZERO_RESET = 8'h00;
    localparam logic [7:0] WAKE_MASK_RESET = 8'h00;
    localparam logic [3:0] CONFIG_RESET = 4'h3;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SHORT_STARTUP_DELAY = 2;
    localparam int LONG_STARTUP_DELAY = 128;
    localparam int POWER_ON_WAIT_MS = 100;
    localparam int POWER_ON_WAIT_CYC = POWER_ON_WAIT_MS * 1000000 / CLK_PERIOD_NS;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [4:0] {
        PMW_RUN = 5'h01,
        PMW_IDLE = 5'h02,
        PMW_SLEEP = 5'h04,
        PMW_WAKE = 5'h08,
        PMW_RSTWAIT = 5'h10
    } pmw_state_e;
    typedef struct packed {
        logic fast_rc_run;
        logic slow_xtal_run;
        logic slow_xtal_lp;
        logic slow_rc_run;
        logic sys_slow;
    } pmw_osc_s;
endpackage : pmw_pkg

// [rtl/pmw_sync.sv]
// two flip-flop level synchroniser
`timescale 1ns/10ps
module pmw_sync #(
    parameter int W = 1
) (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] stage1;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_q;
    always_comb begin
        next_stage1 = d_in;
        next_q = stage1;
    end
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            stage1 <= '1;
            q_out <= '1;
        end else begin
            stage1 <= next_stage1;
            q_out <= next_q;
        end
    end
endmodule : pmw_sync

// [dv/pmw_far_model.sv]
// far-side model: oscillators, external clear pin, pulled-up port a pins
`timescale 1ns/10ps
module pmw_far_model (
    input wire logic clock_in,
    input wire logic [7:0] port_a_low_in,
    input wire logic clear_req_in,
    output logic fast_clk_out,
    output logic slow_clk_out,
    output logic external_clear_pin_b_out,
    output logic [7:0] port_a_out
);
    logic [3:0] div = 4'h0;
    initial fast_clk_out = 1'b0;
    // crystals run free; slow one far below the fast one
    always @(posedge clock_in) begin
        fast_clk_out <= ~fast_clk_out;
        div <= div + 4'h1;
    end
    assign slow_clk_out = div[3];
    // pull-ups hold pins high unless pulled low on request
    assign port_a_out = ~port_a_low_in;
    assign external_clear_pin_b_out = ~clear_req_in;
endmodule : pmw_far_model

// [dv/pmw_ctrl_tb.sv]
// self-checking bench for the power mode and wake-up controller
`timescale 1ns/10ps
module pmw_ctrl_tb;
    import pmw_pkg::*;
    logic clock_in, rst_b_in, stack_full, wdt_ovf, clr_req, fclk, sclk, pin_b;
    logic [7:0] pa_low, irq_req, irq_en, pa;
    logic [31:0] awaddr, wdata, araddr, rdata, r;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    logic rvalid, rready, sys_clk, cpu_run, wdt_clr, wdt_run, pcsp, full_rst, irq_srv;
    logic [1:0] bresp, rresp;
    logic [65:0] e;
    logic [65:0] exp_q[$];
    pmw_osc_s osc;
    int num_errors = 0;
    int compares = 0;
    int n_pcsp = 0;
    int n_srv = 0;
    int n_clr = 0;
    int n, k;
    int n_tog = 0;
    logic sys_clk_d;
    pmw_far_model pmw_far_model_inst (.clock_in(clock_in), .port_a_low_in(pa_low),
        .clear_req_in(clr_req), .fast_clk_out(fclk), .slow_clk_out(sclk),
        .external_clear_pin_b_out(pin_b), .port_a_out(pa));
    pmw_ctrl #(.RESET_WAIT_CYC(20)) pmw_ctrl_inst (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .fast_clk_in(fclk), .slow_clk_in(sclk), .external_clear_pin_b_in(pin_b),
        .port_a_in(pa), .irq_req_in(irq_req), .irq_enabled_in(irq_en),
        .stack_full_in(stack_full), .wdt_overflow_in(wdt_ovf), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .osc_out(osc), .sys_clk_out(sys_clk), .cpu_run_out(cpu_run),
        .wdt_clear_out(wdt_clr), .wdt_run_out(wdt_run), .pc_sp_reset_out(pcsp),
        .full_reset_out(full_rst), .irq_service_out(irq_srv));
    task cmp(input logic [33:0] got, input logic [33:0] want);
        compares++;
        if (got !== want) begin
            num_errors++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, want);
        end
    endtask : cmp
    task bit_chk(input logic got, input logic want);
        cmp({33'h0, got}, {33'h0, want});
    endtask : bit_chk
    task cyc(input int c);
        repeat (c) @(posedge clock_in);
    endtask : cyc
    task wait_run();
        n = 0;
        while (cpu_run !== 1'b1 && n < 400) begin
            @(posedge clock_in);
            n++;
        end
        if (n >= 400) num_errors++;
    endtask : wait_run
    task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] rsp);
        exp_q.push_back({rsp, 64'h0});
        @(posedge clock_in);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock_in);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask : wr
    task rd(input logic [31:0] a, input logic [31:0] d, input logic [31:0] m,
            input logic [1:0] rsp);
        exp_q.push_back({rsp, m, d});
        @(posedge clock_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock_in);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask : rd
    task complete_run();
        $display("counts: %0d compares, %0d errors", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    // results are matched against the oldest note as each handshake completes
    always @(posedge clock_in) begin
        if (bvalid === 1'b1 && bready === 1'b1) begin
            e = exp_q.pop_front();
            cmp({32'h0, bresp}, {32'h0, e[65:64]});
        end
        if (rvalid === 1'b1 && rready === 1'b1) begin
            e = exp_q.pop_front();
            cmp({rresp, rdata & e[63:32]}, {e[65:64], e[31:0] & e[63:32]});
        end
        if (pcsp === 1'b1) n_pcsp++;
        if (irq_srv === 1'b1) n_srv++;
        if (wdt_clr === 1'b1) n_clr++;
        if (sys_clk !== sys_clk_d) n_tog++;
        sys_clk_d = sys_clk;
    end
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    initial begin
        #200000;
        num_errors++;
        complete_run();
    end
    initial begin
        rst_b_in = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, clr_req, stack_full, wdt_ovf} = '0;
        {awaddr, wdata, araddr, pa_low, irq_req, irq_en} = '0;
        r = $urandom(69);
        cyc(12);
        rst_b_in <= 1'b1;
        rd(ADDR_SYSTEM_CONTROL_ZERO, 32'h0, 32'hff, RESP_OKAY);
        rd(ADDR_CONFIG, 32'h3, 32'hff, RESP_OKAY);
        rd(ADDR_STATUS, 32'h04, 32'h7f, RESP_OKAY);
        rd(32'h20, 32'h0, 32'hffffffff, RESP_SLVERR);
        wr(32'h20, 32'h1, RESP_SLVERR);
        r = $urandom & 32'hff;
        wr(ADDR_WAKE_MASK, r, RESP_OKAY);
        rd(ADDR_WAKE_MASK, r, 32'hffffffff, RESP_OKAY);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_SYSTEM_CONTROL_ZERO, i, RESP_OKAY);
            rd(ADDR_SYSTEM_CONTROL_ZERO, i, 32'hff, RESP_OKAY);
            cyc(20);
            bit_chk(osc.slow_xtal_lp, i[1]);
            bit_chk(osc.sys_slow, i[0]);
            bit_chk(osc.fast_rc_run, !i[0]);
            bit_chk(osc.slow_xtal_run, 1'b1);
            k = n_tog;
            cyc(16);
            bit_chk((n_tog - k) == (i[0] ? 2 : 16), 1'b1);
        end
        // slow select left set: other configs must ignore it
        for (int c = 0; c < 3; c++) begin
            wr(ADDR_CONFIG, c, RESP_OKAY);
            cyc(20);
            bit_chk(osc.sys_slow, 1'b0);
            bit_chk(osc.slow_xtal_run, 1'b0);
        end
        wr(ADDR_CONFIG, 32'h3, RESP_OKAY);
        wr(ADDR_SYSTEM_CONTROL_ZERO, 32'h0, RESP_OKAY);
        $display("test modes done");
        wr(ADDR_WAKE_MASK, 32'h01, RESP_OKAY);
        k = n_clr;
        wr(ADDR_COMMAND, 32'h1, RESP_OKAY);
        cyc(4);
        rd(ADDR_STATUS, 32'h09, 32'h7f, RESP_OKAY);
        bit_chk(n_clr > k, 1'b1);
        bit_chk(osc.slow_xtal_run, 1'b1);
        bit_chk(osc.slow_rc_run, 1'b1);
        bit_chk(cpu_run, 1'b0);
        pa_low <= 8'h08;
        cyc(10);
        bit_chk(cpu_run, 1'b0);
        pa_low <= 8'h09;
        wait_run();
        bit_chk(n >= 2 && n <= 10, 1'b1);
        pa_low <= 8'h00;
        rd(ADDR_STATUS, 32'h05, 32'h7f, RESP_OKAY);
        $display("test port wake done");
        wr(ADDR_CONFIG, 32'h6, RESP_OKAY);
        wr(ADDR_COMMAND, 32'h1, RESP_OKAY);
        cyc(4);
        rd(ADDR_STATUS, 32'h11, 32'h7f, RESP_OKAY);
        bit_chk(wdt_run, 1'b0);
        bit_chk(osc.fast_rc_run, 1'b0);
        k = n_pcsp;
        wdt_ovf <= 1'b1;
        cyc(4);
        wdt_ovf <= 1'b0;
        wait_run();
        bit_chk(n_pcsp == k + 1, 1'b1);
        rd(ADDR_STATUS, 32'h07, 32'h7f, RESP_OKAY);
        wr(ADDR_COMMAND, 32'h2, RESP_OKAY);
        rd(ADDR_STATUS, 32'h0, 32'h1, RESP_OKAY);
        $display("test watchdog wake done");
        wr(ADDR_CONFIG, 32'h0, RESP_OKAY);
        irq_en <= 8'h02;
        irq_req <= 8'h02;
        k = n_srv;
        wr(ADDR_COMMAND, 32'h1, RESP_OKAY);
        cyc(20);
        rd(ADDR_STATUS, 32'h11, 32'h7f, RESP_OKAY);
        irq_req <= 8'h00;
        cyc(5);
        irq_req <= 8'h02;
        wait_run();
        bit_chk(n >= 128 && n <= 140, 1'b1);
        bit_chk(n_srv == k + 1, 1'b1);
        irq_req <= 8'h00;
        $display("test interrupt wake done");
        wr(ADDR_CONFIG, 32'h3, RESP_OKAY);
        wr(ADDR_SYSTEM_CONTROL_ZERO, 32'h2, RESP_OKAY);
        wr(ADDR_COMMAND, 32'h1, RESP_OKAY);
        cyc(4);
        clr_req <= 1'b1;
        cyc(6);
        bit_chk(full_rst, 1'b1);
        clr_req <= 1'b0;
        wait_run();
        bit_chk(n >= 148 && n <= 160, 1'b1);
        rd(ADDR_SYSTEM_CONTROL_ZERO, 32'h0, 32'hff, RESP_OKAY);
        rd(ADDR_STATUS, 32'h04, 32'h7f, RESP_OKAY);
        $display("test reset wake done");
        complete_run();
    end
endmodule : pmw_ctrl_tb
